// [logic/programming_io_state_hold.v]
// Purpose : Forces user pin states while the device is in programming mode
// Assumes : Single clock i_clk_sys at 250 MHz; i_prog_mode comes from a pin domain
// Notes   : Per-pin state select, optional detailed cell loading
// Overview of operation
// - In programming mode each pin drives high, drives low, holds its last value or floats, as selected.
// - The last-known option captures the pin's drive at programming entry and holds it until exit.
// - Default cells (in,oe,out) are 1,0,0 for float, 1,1,0 for low, 0,1,1 for high, sampled for last-known.
// - An output enable cell of 0 floats the pin whatever the other cells hold.
// - Detailed mode lets the input cell be loaded per pin, and the output cell too when the pin floats.
// - Don't-care cells (input always, output when enable is 0) never change the pin's output.
// - All three cells loaded with 1 at the drive-high select drives the pin high and stores 1 in the input cell.
`timescale 1ns/10ps
`include "prog_io_state_map.vh"
module programming_io_state_hold
#(
   parameter N_PINS = 8
)
(
   // Clock, reset, enable
   input  wire                i_clk_sys,
   input  wire                i_sys_rst,
   input  wire                i_ce,
   // Programming mode control (asynchronous level)
   input  wire                i_prog_mode,
   // Configuration: 2 bits of state select and 3 detail cells per pin
   input  wire [2*N_PINS-1:0] i_pin_state,
   input  wire                i_detail_mode,
   input  wire [3*N_PINS-1:0] i_detail_cells,
   input  wire                i_cell_load,
   // User logic drive and pad inputs
   input  wire [N_PINS-1:0]   i_user_out,
   input  wire [N_PINS-1:0]   i_user_oe,
   input  wire [N_PINS-1:0]   i_pad_in,
   // Pad drive
   output wire [N_PINS-1:0]   o_pad_out,
   output wire [N_PINS-1:0]   o_pad_oe,
   // Status
   output wire [3*N_PINS-1:0] o_cells,
   output reg                 o_prog_active
);

reg                prog_meta_reg;
reg                prog_sync_reg;
reg  [N_PINS-1:0]  pad_meta_reg;
reg  [N_PINS-1:0]  pad_sync_reg;
reg                load_pend_reg;
wire               prog_entry;

// Two-stage synchronisers; the first stage is read by nothing else
always @(posedge i_clk_sys or posedge i_sys_rst)
begin
   if (i_sys_rst)
   begin
      prog_meta_reg <= 1'b0;
      prog_sync_reg <= 1'b0;
      pad_meta_reg  <= {N_PINS{1'b0}};
      pad_sync_reg  <= {N_PINS{1'b0}};
   end
   else if (i_ce)
   begin
      prog_meta_reg <= i_prog_mode;
      prog_sync_reg <= prog_meta_reg;
      pad_meta_reg  <= i_pad_in;
      pad_sync_reg  <= pad_meta_reg;
   end
end

// Entry pulse is taken while the pads still follow user drive
assign prog_entry = prog_sync_reg & ~o_prog_active;

// Mode flag and a default load one cycle after entry
always @(posedge i_clk_sys or posedge i_sys_rst)
begin
   if (i_sys_rst)
   begin
      o_prog_active <= 1'b0;
      load_pend_reg <= 1'b0;
   end
   else if (i_ce)
   begin
      o_prog_active <= prog_sync_reg;
      load_pend_reg <= prog_entry;
   end
end

// One slice per pin
genvar g;
generate
   for (g = 0; g < N_PINS; g = g + 1)
   begin : g_pin
      pin_cell_slice u_slice
      (
         .i_clk_sys      (i_clk_sys),
         .i_sys_rst      (i_sys_rst),
         .i_ce           (i_ce),
         .i_prog_active  (o_prog_active),
         .i_prog_entry   (prog_entry),
         .i_pin_state    (i_pin_state[2*g+1:2*g]),
         .i_detail_mode  (i_detail_mode),
         .i_detail_cells (i_detail_cells[3*g+2:3*g]),
         .i_cell_load    (load_pend_reg | (i_cell_load & o_prog_active)),
         .i_user_out     (i_user_out[g]),
         .i_user_oe      (i_user_oe[g]),
         .i_pad_in_sync  (pad_sync_reg[g]),
         .o_pad_out      (o_pad_out[g]),
         .o_pad_oe       (o_pad_oe[g]),
         .o_cells        (o_cells[3*g+2:3*g])
      );
   end
endgenerate

endmodule // programming_io_state_hold

// [logic/prog_io_state_map.vh]
// Purpose : Constants for the programming-mode pin state block
// Assumes : Included by bare name
// Notes   : Pin state selector codes and default cell loadings
`ifndef PROG_IO_STATE_MAP_VH
`define PROG_IO_STATE_MAP_VH

// Pin state selector codes (2 bits)
`define PST_DRIVE_HIGH   2'h0
`define PST_DRIVE_LOW    2'h1
`define PST_LAST_KNOWN   2'h2
`define PST_TRISTATE     2'h3

// Default cell loadings {input, output enable, output}
`define CELLS_TRISTATE   3'h4
`define CELLS_DRIVE_LOW  3'h6
`define CELLS_DRIVE_HIGH 3'h3

// Bit positions inside a 3-bit cell group
`define CELL_IN_BIT      2
`define CELL_OE_BIT      1
`define CELL_OUT_BIT     0

// Cell reset value after reset: tri-state loading
`define CELLS_RESET      3'h4

`endif

// [logic/pin_cell_slice.v]
// Purpose : Three boundary cells and pin drive for one user pin
// Assumes : Controls arrive synchronous to i_clk_sys
// Notes   : In programming mode an output enable cell low forces the pad to float
`timescale 1ns/10ps
`include "prog_io_state_map.vh"
module pin_cell_slice
(
   // Clock and reset
   input  wire       i_clk_sys,
   input  wire       i_sys_rst,
   input  wire       i_ce,
   // Mode control
   input  wire       i_prog_active,
   input  wire       i_prog_entry,
   input  wire [1:0] i_pin_state,
   input  wire       i_detail_mode,
   input  wire [2:0] i_detail_cells,
   input  wire       i_cell_load,
   // User logic and pad-side input
   input  wire       i_user_out,
   input  wire       i_user_oe,
   input  wire       i_pad_in_sync,
   // Pad drive and cell view
   output reg        o_pad_out,
   output reg        o_pad_oe,
   output wire [2:0] o_cells
);

reg  [2:0] cells_reg;
reg  [2:0] cells_next;
reg  [2:0] last_reg;
reg        pad_out_next;
reg        pad_oe_next;

assign o_cells = cells_reg;

// Cell value to load for the selected pin state
always @*
begin
   cells_next = cells_reg;
   if (i_prog_entry)
   begin
      // Capture of pre-programming drive happens at entry
      cells_next = {i_pad_in_sync, i_user_oe, i_user_out};
   end
   else if (i_cell_load)
   begin
      case (i_pin_state)
         `PST_DRIVE_HIGH: cells_next = `CELLS_DRIVE_HIGH;
         `PST_DRIVE_LOW:  cells_next = `CELLS_DRIVE_LOW;
         `PST_TRISTATE:   cells_next = `CELLS_TRISTATE;
         default:         cells_next = last_reg;
      endcase
      if (i_detail_mode)
      begin
         // Input cell is always free; output cell only free when floating
         cells_next[`CELL_IN_BIT] = i_detail_cells[`CELL_IN_BIT];
         if (i_pin_state == `PST_TRISTATE)
            cells_next[`CELL_OUT_BIT] = i_detail_cells[`CELL_OUT_BIT];
         else if (i_pin_state == `PST_DRIVE_HIGH && i_detail_cells == 3'h7)
            cells_next = 3'h7;
      end
   end
end

// Pad drive: cells in programming mode, user logic otherwise
always @*
begin
   if (i_prog_active)
   begin
      pad_oe_next  = cells_reg[`CELL_OE_BIT];
      pad_out_next = cells_reg[`CELL_OE_BIT] & cells_reg[`CELL_OUT_BIT];
   end
   else
   begin
      pad_oe_next  = i_user_oe;
      pad_out_next = i_user_out;
   end
end

// Registers; last_reg keeps the capture even if cells are reloaded
always @(posedge i_clk_sys or posedge i_sys_rst)
begin
   if (i_sys_rst)
   begin
      cells_reg <= `CELLS_RESET;
      last_reg  <= `CELLS_RESET;
      o_pad_out <= 1'b0;
      o_pad_oe  <= 1'b0;
   end
   else if (i_ce)
   begin
      cells_reg <= cells_next;
      if (i_prog_entry)
         last_reg <= {i_pad_in_sync, i_user_oe, i_user_out};
      o_pad_out <= pad_out_next;
      o_pad_oe  <= pad_oe_next;
   end
end

endmodule // pin_cell_slice

// [verif/pad_board_model.sv]
// Purpose: board side of the user pins
// Assumes: no pull on the pins
// Notes: a floating pin wanders every cycle
`timescale 1ns/10ps
module pad_board_model
(
   input  wire       i_clk_sys,
   input  wire [7:0] i_pad_out,
   input  wire [7:0] i_pad_oe,
   output wire [7:0] o_pad_in
);
   reg [7:0] wob = 8'h5a;
   // A stale level must never pass for a driven one
   always @(posedge i_clk_sys) wob <= ~wob;
   assign o_pad_in = (i_pad_out & i_pad_oe) | (wob & ~i_pad_oe);
endmodule // pad_board_model

// [verif/programming_io_state_hold_props.sv]
// Purpose: timing checks on the pin state block
// Assumes: i_ce held high
// Notes: pads trail the cells by one edge
`timescale 1ns/10ps
`include "prog_io_state_map.vh"
module programming_io_state_hold_props #(parameter N_PINS = 8)
(input wire i_clk_sys, i_sys_rst, i_ce, i_prog_mode, i_detail_mode, i_cell_load, o_prog_active,
 input wire [2*N_PINS-1:0] i_pin_state,
 input wire [3*N_PINS-1:0] i_detail_cells, o_cells,
 input wire [N_PINS-1:0] i_user_out, i_user_oe, i_pad_in, o_pad_out, o_pad_oe);
   localparam [3*N_PINS-1:0] inm = {N_PINS{3'h4}};
   wire [N_PINS-1:0] c_in, c_oe, c_out;
   wire [3*N_PINS-1:0] dflt, keep;
   genvar g;
   // Expected default cells; last-known pins keep their capture
   for (g = 0; g < N_PINS; g = g + 1)
   begin : pin
      wire [1:0] s = i_pin_state[2*g+:2];
      assign c_in[g] = o_cells[3*g+`CELL_IN_BIT];
      assign c_oe[g] = o_cells[3*g+`CELL_OE_BIT];
      assign c_out[g] = o_cells[3*g+`CELL_OUT_BIT];
      assign keep[3*g+:3] = {3{s == `PST_LAST_KNOWN}};
      assign dflt[3*g+:3] = s == `PST_DRIVE_HIGH ? `CELLS_DRIVE_HIGH : s == `PST_DRIVE_LOW ?
         `CELLS_DRIVE_LOW : s == `PST_TRISTATE ? `CELLS_TRISTATE : 3'h0;
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   sequence s_entry; !o_prog_active ##1 o_prog_active; endsequence
   sequence s_held; o_prog_active [*3]; endsequence
   a_oe_follows_cell: assert property (s_held |-> o_pad_oe == $past(c_oe))
      else $error("pad enable off cell");
   a_out_follows_cell: assert property (s_held |-> o_pad_out == ($past(c_out) & $past(c_oe)))
      else $error("pad value off cell");
   // Pad level reaches the input cell through two sync stages, so it is three edges old
   a_entry_capture: assert property (s_entry |-> c_oe == $past(i_user_oe) && c_out == $past(i_user_out) &&
      c_in == $past(i_pad_in, 3)) else $error("capture wrong");
   // Selection is taken at the edge after entry, so compare with what stood then
   a_entry_select: assert property (s_entry ##0 !i_detail_mode |=>
      o_cells == ($past(dflt) | ($past(o_cells) & $past(keep)))) else $error("default cells wrong");
   a_detail_in: assert property (o_prog_active && i_cell_load && i_detail_mode |=>
      (o_cells & inm) == ($past(i_detail_cells) & inm)) else $error("input cell not loaded");
   a_all_ones: assert property (o_prog_active && i_cell_load && i_detail_mode && &i_detail_cells &&
      i_pin_state == 0 |=> &o_cells ##1 &o_pad_out && &o_pad_oe) else $error("all ones not driven high");
   a_user_return: assert property (!o_prog_active && !$past(o_prog_active) && !$past(i_sys_rst) |->
      o_pad_oe == $past(i_user_oe) && o_pad_out == $past(i_user_out)) else $error("pads not user driven");
   a_load_refused: assert property (!o_prog_active ##1 !o_prog_active |-> $stable(o_cells))
      else $error("cells moved while idle");
endmodule // programming_io_state_hold_props
bind programming_io_state_hold programming_io_state_hold_props #(.N_PINS(N_PINS)) props_i (.i_clk_sys,
   .i_sys_rst, .i_ce, .i_prog_mode, .i_detail_mode, .i_cell_load, .o_prog_active, .i_pin_state,
   .i_detail_cells, .o_cells, .i_user_out, .i_user_oe, .i_pad_in, .o_pad_out, .o_pad_oe);

// [verif/programming_io_state_hold_bench.sv]
// Purpose: random rounds of entry, detail load and exit
// Assumes: eight pins, clock enable held high
// Notes: user drive flips after entry so a held value shows
`timescale 1ns/10ps
module programming_io_state_hold_bench;
   reg clk = 0, rst = 1, pm = 0, dm = 0, ld = 0;
   reg [15:0] st = 0, x;
   reg [23:0] dc = 0;
   reg [7:0] uo = 0, ue = 0;
   wire [7:0] pin, po, pe;
   wire [23:0] cl;
   wire act;
   integer error_cnt = 0, checked = 0, r;
   initial forever #2 clk = ~clk;
   programming_io_state_hold programming_io_state_hold_i (.i_clk_sys(clk), .i_sys_rst(rst), .i_ce(1'b1),
      .i_prog_mode(pm), .i_pin_state(st), .i_detail_mode(dm), .i_detail_cells(dc), .i_cell_load(ld),
      .i_user_out(uo), .i_user_oe(ue), .i_pad_in(pin), .o_pad_out(po), .o_pad_oe(pe), .o_cells(cl),
      .o_prog_active(act));
   pad_board_model pad_board_model_i (.i_clk_sys(clk), .i_pad_out(po), .i_pad_oe(pe), .o_pad_in(pin));
   task give_verdict;
      if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input [31:0] a, b);
      checked++;
      if (a !== b)
      begin
         error_cnt++;
         $display("BAD %0t %h %h", $time, a, b);
      end
   endtask
   // Bounded wait, the mode flag passes a synchroniser
   task wt(input v);
      repeat (8) if (act !== v) @(negedge clk);
      chk(act, v);
   endtask
   // Expected {enable, value} of each pad for the selected states
   function [15:0] xp(input [15:0] s, input [7:0] e, o);
      integer k;
      for (k = 0; k < 8; k++)
         case (s[2*k+:2])
            0: {xp[k+8], xp[k]} = 2'b11;
            1: {xp[k+8], xp[k]} = 2'b10;
            2: {xp[k+8], xp[k]} = {e[k], e[k] & o[k]};
            default: {xp[k+8], xp[k]} = 2'b00;
         endcase
   endfunction
   initial
   begin
      void'($urandom(52));
      repeat (8) @(posedge clk);
      @(negedge clk) rst = 0;
      for (r = 0; r < 24; r++)
      begin
         @(negedge clk);
         {uo, ue} = 16'($urandom);
         st = r < 4 ? {8{r[1:0]}} : 16'($urandom);
         pm = 1;
         x = xp(st, ue, uo);
         wt(1);
         {uo, ue} = ~{uo, ue};
         repeat (2) @(negedge clk);
         chk({pe, po}, x);
         // Odd rounds load all ones at drive high
         dm = 1;
         ld = 1;
         dc = r[0] ? 24'hffffff : 24'($urandom);
         if (r[0])
         begin
            st = 16'h0000;
            x = 16'hffff;
         end
         @(negedge clk) ld = 0;
         chk(cl & 24'h924924, dc & 24'h924924);
         @(negedge clk) chk({pe, po}, x);
         pm = 0;
         dm = 0;
         wt(0);
         @(negedge clk) chk({pe, po}, {ue, uo});
      end
      give_verdict;
   end
   // A round needs well under 40 cycles
   initial
   begin
      #8000;
      error_cnt++;
      give_verdict;
   end
endmodule // programming_io_state_hold_bench
